/* core/tsr_map.vh */
// Constants for the serial register interface of the temperature sensor.
// Assumes inclusion by bare name from files under core/.
`ifndef TSR_MAP_VH
`define TSR_MAP_VH

// Frame layout in serial clocks
`define TSR_TX_BITS       6'd16
`define TSR_FRAME_BITS    6'd32
`define TSR_DRIVE_BITS    6'd14
// Control codes, low byte only
`define TSR_CODE_SHUTDOWN 8'hFF
`define TSR_CODE_CONVERT  8'h00
// Temperature word fixed fields
`define TSR_TEMP_LSB_POS  5
`define TSR_TEMP_FILL     3'h7
// Identification word fixed fields
`define TSR_ID_FILL       3'h0
// Reset values
`define TSR_RST_SHUTDOWN  1'b0
`define TSR_RST_TEMP      11'h000

`endif

/* core/tsr_word_store.v */
// Small storage holding the two readable words with registered read data.
// Assumes temperature updates arrive on the same clock.
`timescale 1ns/1ns
`include "tsr_map.vh"

module tsr_word_store #(
    parameter [10:0] ID_VALUE = 11'h2A5  // Arbitrary identification value
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        temp_we,
    input  wire [10:0] temp_in,
    input  wire        sel_id,
    output reg  [15:0] rd_word
);
    reg [10:0] temp_store;

    // Latest conversion result
    always @(posedge clock) begin
        if (rst) begin
            temp_store <= `TSR_RST_TEMP;
        end else if (temp_we) begin
            temp_store <= temp_in;
        end
    end

    // Registered read of the selected word; low two bits never driven
    always @(posedge clock) begin
        if (rst) begin
            rd_word <= 16'h0000;
        end else if (sel_id) begin
            rd_word <= {ID_VALUE, `TSR_ID_FILL, 2'b00};
        end else begin
            rd_word <= {temp_store, `TSR_TEMP_FILL, 2'b00};
        end
    end
endmodule

/* core/tsr_serial_regs.v */
// Serial register interface of a digital temperature sensor.
// Assumes link pins are asynchronous to clock and pass two flops here.
// Assumes the link clock half period spans at least eight clock cycles.
// Assumes temperature results arrive on clock as single-cycle strobes.
//
// Summary of operation
// - Low byte all ones enters shutdown
// - Low byte all zeros resumes conversion
// - Other codes enter sticky test state
// - Bits one and zero left undriven
// - Temperature bits four to two are ones
// - Bits fifteen to five hold temperature
// - Bits fifteen to five hold maker code
// - Identification bits four to two low
// - Shutdown returns identification instead of temperature
// - Frame is sixteen transmit, sixteen receive clocks
// - Drive on falling, sample on rising
// - Decode last eight bits before deselect
// - Release line after fourteen bits
`timescale 1ns/1ns
`include "tsr_map.vh"

module tsr_serial_regs #(
    parameter [10:0] ID_VALUE = 11'h2A5  // Arbitrary identification value
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        chip_select_n,
    input  wire        serial_bit_clock,
    input  wire        sio_in,
    output reg         sio_out,
    output reg         sio_oe_n,
    input  wire        temp_valid,
    input  wire [10:0] temp_value,
    output reg         shutdown,
    output reg         test_state,
    output reg  [7:0]  last_code
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    // Vector order: select, link clock, data line from bit zero up
    localparam PIN_CS  = 0;
    localparam PIN_SCK = 1;
    localparam PIN_SIO = 2;
    localparam PIN_NUM = 3;
    // Idle levels; reset loads them so no false edge follows reset
    localparam [2:0] PIN_IDLE = 3'b001;

    wire [2:0] pin_raw;
    wire [2:0] pin_sync;
    reg        cs_n_q;
    reg        sck_q;

    assign pin_raw = {sio_in, serial_bit_clock, chip_select_n};

    // Two flops per pin; only stage one feeds stage two
    genvar g;
    generate
        for (g = 0; g < PIN_NUM; g = g + 1) begin : g_sync
            reg stage_one;
            reg stage_two;

            always @(posedge clock) begin
                if (rst) begin
                    stage_one <= PIN_IDLE[g];
                    stage_two <= PIN_IDLE[g];
                end else begin
                    stage_one <= pin_raw[g];
                    stage_two <= stage_one;
                end
            end

            assign pin_sync[g] = stage_two;
        end
    endgenerate

    // Delayed copies of select and link clock for edge finding
    always @(posedge clock) begin
        if (rst) begin
            cs_n_q <= PIN_IDLE[PIN_CS];
            sck_q  <= PIN_IDLE[PIN_SCK];
        end else begin
            cs_n_q <= pin_sync[PIN_CS];
            sck_q  <= pin_sync[PIN_SCK];
        end
    end

    // Link clock edges are only honoured while selected; a link clock that toggles
    // outside a frame cannot advance the bit counter.
    wire cs_n      = pin_sync[PIN_CS];
    wire sck       = pin_sync[PIN_SCK];
    wire sio_bit   = pin_sync[PIN_SIO];
    wire sel_fall  = cs_n_q & ~cs_n;
    wire sel_rise  = ~cs_n_q & cs_n;
    wire sck_rise  = ~cs_n & ~sck_q & sck;
    wire sck_fall  = ~cs_n & sck_q & ~sck;

    ////////////////////////////////////////////////////////////////////////
    // Code classification used by the mode update only
    function [1:0] code_kind;
        input [7:0] code;
        begin
            if (code == `TSR_CODE_SHUTDOWN) begin
                code_kind = 2'd1;
            end else if (code == `TSR_CODE_CONVERT) begin
                code_kind = 2'd2;
            end else begin
                code_kind = 2'd3;
            end
        end
    endfunction

    // Whether the transmit phase may drive the line for the next bit;
    // shared by the frame opening and every falling link clock edge of transmit.
    function line_driven;
        input [5:0] rises;
        input       frozen;
        begin
            line_driven = (rises < `TSR_DRIVE_BITS) && !frozen;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Word store
    // The store registers its read word, so the mode seen at a select
    // fall is the one in force at least a cycle before it.
    wire [15:0] rd_word;

    tsr_word_store #(
        .ID_VALUE (ID_VALUE)
    ) u_store (
        .clock   (clock),
        .rst     (rst),
        .temp_we (temp_valid & ~shutdown),
        .temp_in (temp_value),
        .sel_id  (shutdown),
        .rd_word (rd_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame state
    localparam ST_IDLE = 2'd0;
    localparam ST_TX   = 2'd1;
    localparam ST_RX   = 2'd2;
    localparam ST_DONE = 2'd3;

    reg [1:0]  state;
    reg [1:0]  next_state;
    reg [5:0]  bit_count;
    reg [15:0] tx_shift;
    reg [7:0]  rx_shift;
    reg [5:0]  rx_count;
    reg        got_bits;

    // Phase flags shared by the data paths
    wire in_idle = (state == ST_IDLE);
    wire in_tx   = (state == ST_TX);
    wire in_rx   = (state == ST_RX);

    // A frame opens on the select fall, counts sixteen rising link clock
    // edges of transmit, then up to sixteen of receive. Deselect returns
    // to idle from any phase, which is how a cut frame is abandoned.
    // phase sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (sel_fall) begin
                    next_state = ST_TX;
                end
            end
            ST_TX: begin
                if (cs_n) begin
                    next_state = ST_IDLE;
                end else if (sck_rise && bit_count == `TSR_TX_BITS - 6'd1) begin
                    next_state = ST_RX;
                end
            end
            ST_RX: begin
                if (cs_n) begin
                    next_state = ST_IDLE;
                end else if (sck_rise && bit_count == `TSR_FRAME_BITS - 6'd1) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (cs_n) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Bit counting over rising edges of the link clock
    // The count saturates at the frame length so extra clocks after the
    // receive phase cannot wrap it back into the transmit window.
    always @(posedge clock) begin
        if (rst) begin
            state     <= ST_IDLE;
            bit_count <= 6'd0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE) begin
                bit_count <= 6'd0;
            end else if (sck_rise && bit_count != `TSR_FRAME_BITS) begin
                bit_count <= bit_count + 6'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit path
    // Word is loaded at select; the store has had a cycle since mode changed,
    // so a shutdown written in one frame picks the word of the next frame.
    always @(posedge clock) begin
        if (rst) begin
            tx_shift <= 16'h0000;
            sio_out  <= 1'b0;
        end else if (cs_n || in_idle && !sel_fall) begin
            // Released line shows zero so no stale bit lingers
            sio_out  <= 1'b0;
        end else if (sel_fall) begin
            tx_shift <= {rd_word[14:0], 1'b0};
            sio_out  <= rd_word[15];
        end else if (sck_fall && in_tx) begin
            tx_shift <= {tx_shift[14:0], 1'b0};
            sio_out  <= tx_shift[15];
        end
    end

    // Line enable; kept apart so the release point is easy to audit
    always @(posedge clock) begin
        if (rst) begin
            sio_oe_n <= 1'b1;
        end else if (cs_n || in_idle && !sel_fall) begin
            sio_oe_n <= 1'b1;
        end else if (sel_fall) begin
            sio_oe_n <= ~line_driven(6'd0, test_state);
        end else if (sck_fall && in_tx) begin
            sio_oe_n <= ~line_driven(bit_count, test_state);
        end else if (!in_tx) begin
            sio_oe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive path
    // Only rising edges inside the receive phase shift data in; the
    // sixteenth rise closes transmit and is not a data bit for us.
    // sample on rising edge
    always @(posedge clock) begin
        if (rst) begin
            rx_shift <= 8'h00;
            rx_count <= 6'd0;
            got_bits <= 1'b0;
        end else if (sel_fall) begin
            rx_count <= 6'd0;
            got_bits <= 1'b0;
        end else if (sck_rise && (in_rx || next_state == ST_RX)) begin
            if (in_rx) begin
                rx_shift <= {rx_shift[6:0], sio_bit};
                rx_count <= rx_count + 6'd1;
                got_bits <= (rx_count >= 6'd7);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode update at deselect
    // Partial writes under eight bits are ignored so a pure read frame
    // never disturbs the mode.
    // The decode waits for deselect because only the final eight bits
    // count; an earlier byte of a long write is simply shifted through.
    always @(posedge clock) begin
        if (rst) begin
            shutdown   <= `TSR_RST_SHUTDOWN;
            test_state <= 1'b0;
            last_code  <= 8'h00;
        end else if (sel_rise && got_bits) begin
            last_code <= rx_shift;
            case (code_kind(rx_shift))
                2'd1: shutdown <= 1'b1;
                2'd2: shutdown <= 1'b0;
                default: test_state <= 1'b1;
            endcase
        end
    end

    // The read words are composed inside the word store from the map
    // constants: temperature or identification in bits fifteen to five,
    // a three-bit fill below them and two bits that are never driven.
    // A host that stops reading early simply cuts the frame; the mode is
    // untouched unless eight receive bits arrived.
endmodule

/* test/tsr_properties.sv */
// Pin checker for the sensor serial registers.
// Assumes every link pin is sampled by clock.
`timescale 1ns/1ns
module tsr_properties #(
    parameter [10:0] ID_VALUE = 11'h2A5
) (
    input wire       clock,
    input wire       rst,
    input wire       chip_select_n,
    input wire       serial_bit_clock,
    input wire       sio_out,
    input wire       sio_oe_n,
    input wire       shutdown,
    input wire       test_state,
    input wire [7:0] last_code
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Select fall seen outside test state
    sequence s_open;
        $fell(chip_select_n) && !test_state;
    endsequence
    // Mode follows the decoded byte
    property p_off; last_code == 8'hFF && !test_state |-> shutdown; endproperty
    a_off: assert property (p_off) else $error("FF left running");
    property p_on; last_code == 8'h00 && !test_state |-> !shutdown; endproperty
    a_on: assert property (p_on) else $error("00 left shut down");
    property p_test; last_code != 8'h00 && last_code != 8'hFF |-> test_state; endproperty
    a_test: assert property (p_test) else $error("odd code no test");
    // Line and mode behaviour inside a frame
    property p_drive; s_open |-> ##[1:5] !sio_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("frame not driven");
    property p_id; s_open ##0 shutdown |-> ##[1:5] !sio_oe_n && sio_out == ID_VALUE[10];
    endproperty
    a_id: assert property (p_id) else $error("bad first id bit");
    property p_hold; !sio_oe_n && serial_bit_clock |-> $stable(sio_out); endproperty
    a_hold: assert property (p_hold) else $error("data moved on high");
    property p_rel; $rose(sio_oe_n) && !chip_select_n |=> sio_oe_n [*8]; endproperty
    a_rel: assert property (p_rel) else $error("line driven again");
    property p_mode; !chip_select_n [*6] |=> $stable(shutdown) && $stable(test_state);
    endproperty
    a_mode: assert property (p_mode) else $error("mode moved in frame");
endmodule
bind tsr_serial_regs tsr_properties #(.ID_VALUE(ID_VALUE)) u_props (.clock(clock),
    .rst(rst), .chip_select_n(chip_select_n), .serial_bit_clock(serial_bit_clock),
    .sio_out(sio_out), .sio_oe_n(sio_oe_n), .shutdown(shutdown),
    .test_state(test_state), .last_code(last_code));

/* test/tsr_ctl_model.sv */
// Bus controller model running frames at the sensor pins.
// Assumes 100 MHz clock; half a link period is 8 clocks.
`timescale 1ns/1ns
module tsr_ctl_model (
    input  wire        clock,
    input  wire        sio_out,
    input  wire        sio_oe_n,
    output reg         chip_select_n = 1'b1,
    output reg         serial_bit_clock = 1'b0,
    output reg         ctl_bit = 1'b0,
    output reg  [31:0] seen = 32'h0,
    output reg         done = 1'b0
);
    integer i;
    task half;
        repeat (8) @(negedge clock);
    endtask
    task frame(input [15:0] wr, input integer nrx);
        begin
            chip_select_n = 1'b0;
            half;
            for (i = 0; i < 16 + nrx; i = i + 1) begin
                serial_bit_clock = 1'b1;
                if (i < 16) begin
                    seen[31 - i] = sio_oe_n;
                    seen[15 - i] = sio_out & ~sio_oe_n;
                end
                half;
                serial_bit_clock = 1'b0;
                // Idle line toggles so a stale bit never passes
                ctl_bit = (i >= 15 && i - 15 < nrx) ? wr[nrx + 14 - i] : ~ctl_bit;
                half;
            end
            chip_select_n = 1'b1;
            done = 1'b1;
            repeat (12) @(negedge clock);
            done = 1'b0;
        end
    endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the sensor serial registers.
// Assumes the controller model and bound checker.
`timescale 1ns/1ns
module tb_top;
    localparam [10:0] ID_VALUE = 11'h4C3; // Arbitrary value
    reg         clock;
    reg         rst = 1'b1;
    reg         temp_valid = 1'b0;
    reg  [10:0] temp_value = 11'h000;
    reg  [31:0] r;
    reg  [31:0] exp_q[$];
    integer     failures = 0;
    integer     n_compared = 0;
    wire        cs_n, sck, ctl_bit, sio_out, sio_oe_n, shutdown, test_state, done;
    wire [7:0]  last_code;
    wire [31:0] seen;
    wire        sio_line = sio_oe_n ? ctl_bit : sio_out;
    tsr_serial_regs #(.ID_VALUE(ID_VALUE)) dut_u (.clock(clock), .rst(rst),
        .chip_select_n(cs_n), .serial_bit_clock(sck), .sio_in(sio_line),
        .sio_out(sio_out), .sio_oe_n(sio_oe_n), .temp_valid(temp_valid),
        .temp_value(temp_value), .shutdown(shutdown), .test_state(test_state),
        .last_code(last_code));
    tsr_ctl_model ctl_u (.clock(clock), .sio_out(sio_out), .sio_oe_n(sio_oe_n),
        .chip_select_n(cs_n), .serial_bit_clock(sck), .ctl_bit(ctl_bit),
        .seen(seen), .done(done));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task check(input [31:0] got, input [31:0] want);
        begin
            n_compared = n_compared + 1;
            if (got !== want) begin
                failures = failures + 1;
                $display("[FAIL] %0t got %h want %h", $time, got, want);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Upper half: enables seen per bit, lower: driven data
    function [31:0] tw(input [10:0] v);
        tw = {16'h0003, v, 3'h7, 2'h0};
    endfunction
    task run(input [31:0] e, input [15:0] wr, input integer nrx);
        begin
            exp_q.push_back(e);
            ctl_u.frame(wr, nrx);
        end
    endtask
    task mode(input sd, input ts, input [7:0] code);
        check({22'h0, shutdown, test_state, last_code}, {22'h0, sd, ts, code});
    endtask
    task load(input [10:0] v);
        begin
            temp_value = v;
            temp_valid = 1'b1;
            @(negedge clock);
            temp_valid = 1'b0;
        end
    endtask
    ////////////////////////////////////////
    // Each finished frame is held against the oldest note
    always @(posedge done)
        check(seen, exp_q.pop_front());
    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        r = $urandom(32'h4a460dcc);
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        r = $urandom;
        load(r[10:0]);
        run(tw(r[10:0]), {r[31:24], 8'h00}, 16);
        mode(1'b0, 1'b0, 8'h00);
        run(tw(r[10:0]), 16'h00FF, 8);
        mode(1'b1, 1'b0, 8'hFF);
        load(~r[10:0]);
        run({16'h0003, ID_VALUE, 3'h0, 2'h0}, 16'hFF00, 16);
        mode(1'b0, 1'b0, 8'h00);
        run(tw(r[10:0]), 16'h00FF, 7);
        mode(1'b0, 1'b0, 8'h00);
        run(tw(r[10:0]), {r[23:16], 8'h5A}, 16);
        mode(1'b0, 1'b1, 8'h5A);
        run({16'hFFFF, 16'h0000}, 16'h0000, 0);
        // Mid-run reset clears the sticky test state and the stored word
        rst = 1'b1;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        mode(1'b0, 1'b0, 8'h00);
        run(tw(11'h000), 16'h00FF, 8);
        mode(1'b1, 1'b0, 8'hFF);
        report_and_stop;
    end
endmodule
